// file: sac_step_atten.sv
// Control port of a 7-bit step attenuator: parallel, latched and
// addressed serial programming, power-up defaults, Wishbone status.
// Assumes controller pins asynchronous to clk_sys and a stoppable
// shift clock on link_clk.
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ns
module sac_step_atten #(
  parameter int PUP_DELAY_CYC = sac_pkg::PUP_DELAY_CYC
) (
  input  wire logic        clk_sys,              // System clock
  input  wire logic        sys_rst,              // Sync reset, high
  input  wire logic        link_clk,             // Serial shift clock
  input  wire logic        ser_in,               // Serial data in
  input  wire logic        latch_strobe,         // Latch strobe pin
  input  wire logic        sel_serial,           // Interface select
  input  wire logic [6:0]  parallel_atten_lines, // Parallel state
  input  wire logic        addr_strap_bit0,      // Address strap 0
  input  wire logic        addr_strap_bit1,      // Address strap 1
  input  wire logic        addr_strap_bit2,      // Address strap 2
  input  wire logic        wb_cyc_i,             // Bus cycle
  input  wire logic        wb_stb_i,             // Bus strobe
  input  wire logic        wb_we_i,              // Write enable
  input  wire logic [7:0]  wb_adr_i,             // Byte address
  input  wire logic [3:0]  wb_sel_i,             // Byte selects
  input  wire logic [31:0] wb_dat_i,             // Write data
  output logic      [31:0] wb_dat_o,             // Read data
  output logic             wb_ack_o,             // Acknowledge
  output logic      [7:0]  atten_state,          // Applied state
  output logic             serial_mode           // Serial selected
);

  localparam int CNT_W = $clog2(PUP_DELAY_CYC + 1);
  localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(PUP_DELAY_CYC - 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST =
    CNT_W'(sac_pkg::SETTLE_CYC - 1);

  function automatic logic [7:0] bump(input logic [7:0] c,
                                      input logic       inc,
                                      input logic       clr);
    logic [7:0] r;
    r = c;
    // A new event beats a clear in the same cycle
    if (clr)
      r = inc ? 8'h01 : sac_pkg::RST_COUNT;
    else if (inc && c != 8'hFF)
      r = c + 8'h01;
    return r;
  endfunction

  // Synchronised pins
  logic [6:0] par_q;
  logic [2:0] strap_q;
  logic       sel_q;
  logic       le_q;
  logic       le_d_ff;

  sac_sync #(.W(7), .RST(7'h00)) u_sync_par (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .d       (parallel_atten_lines),
    .q       (par_q)
  );

  sac_sync #(.W(5), .RST(5'h00)) u_sync_ctl (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .d       ({sel_serial, latch_strobe, addr_strap_bit2,
               addr_strap_bit1, addr_strap_bit0}),
    .q       ({sel_q, le_q, strap_q})
  );

  // Frame register on the shift clock
  logic [sac_pkg::FRAME_W-1:0] shift_word;

  sac_shift #(.W(sac_pkg::FRAME_W)) u_shift (
    .link_clk     (link_clk),
    .ser_in       (ser_in),
    .latch_strobe (latch_strobe),
    .frame_ff     (shift_word)
  );

  // Register state
  sac_pkg::sac_state_t state_ff;
  sac_pkg::sac_state_t nxt_state;
  logic [CNT_W-1:0]    cnt_ff;
  logic [CNT_W-1:0]    nxt_cnt;
  logic [7:0]          atten_ff;
  logic [7:0]          nxt_atten;
  logic                pup_direct_ff;
  logic                nxt_pup_direct;
  logic [15:0]         frame_ff;
  logic                match_ff;
  logic [7:0]          acc_ff;
  logic [7:0]          rej_ff;
  logic                ack_ff;
  logic [31:0]         rdat_ff;
  logic                serial_ff;

  // Strobe rise seen in the system domain
  wire le_rise = le_q & ~le_d_ff;

  // The shift clock is stopped while the strobe is high, so the
  // frame is static when sampled on the synchronised rise.
  // transfer on strobe
  wire        take_frame = le_rise & sel_q;
  wire [7:0]  frm_atten  = shift_word[sac_pkg::ATTEN_LSB +: 8];
  wire [7:0]  frm_addr   = shift_word[sac_pkg::ADDR_LSB +: 8];
  wire        addr_hit   = (frm_addr[sac_pkg::ADDR_W-1:0] == strap_q);
  wire        accept     = take_frame & addr_hit;
  wire        reject     = take_frame & ~addr_hit;

  wire [7:0]  par_word   = {atten_ff[7], par_q};

  // Bus decode
  wire        bus_req  = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire        bus_wr   = bus_req & wb_we_i;
  wire        hit_ctrl = (wb_adr_i == sac_pkg::REG_CTRL);
  wire        wr_ctrl  = bus_wr & hit_ctrl & wb_sel_i[0];
  wire        reinit   = wr_ctrl & wb_dat_i[sac_pkg::CTRL_REINIT];
  wire        clr_cnt  = wr_ctrl & wb_dat_i[sac_pkg::CTRL_CLRCNT];

  // Power-up sequencing and attenuation update
  always_comb
  begin
    nxt_state      = state_ff;
    nxt_cnt        = cnt_ff;
    nxt_atten      = atten_ff;
    nxt_pup_direct = pup_direct_ff;
    case (state_ff)
      sac_pkg::ST_SETTLE:
      begin
        // Let the synchronisers fill before reading the mode pins
        nxt_cnt = cnt_ff + CNT_W'(1);
        if (cnt_ff == SETTLE_LAST)
        begin
          nxt_cnt        = '0;
          nxt_pup_direct = ~sel_q & le_q;
          nxt_state      = (~sel_q & le_q) ? sac_pkg::ST_DELAY
                                           : sac_pkg::ST_RUN;
        end
      end
      sac_pkg::ST_DELAY:
      begin
        nxt_cnt = cnt_ff + CNT_W'(1);
        if (cnt_ff == DELAY_LAST)
        begin
          nxt_cnt   = '0;
          nxt_atten = par_word;
          nxt_state = sac_pkg::ST_RUN;
        end
      end
      sac_pkg::ST_RUN:
      begin
        if (sel_q)
        begin
          if (accept)
            nxt_atten = frm_atten;
        end
        else if (le_q)
          nxt_atten = par_word;
      end
      default:
      begin
        nxt_state = sac_pkg::ST_SETTLE;
        nxt_cnt   = '0;
      end
    endcase
    if (reinit)
    begin
      nxt_state = sac_pkg::ST_SETTLE;
      nxt_cnt   = '0;
      nxt_atten = sac_pkg::ATTEN_MAX;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_ff      <= sac_pkg::ST_SETTLE;
      cnt_ff        <= '0;
      atten_ff      <= sac_pkg::ATTEN_MAX;
      pup_direct_ff <= 1'b0;
      le_d_ff       <= 1'b0;
      serial_ff     <= 1'b0;
    end
    else
    begin
      state_ff      <= nxt_state;
      cnt_ff        <= nxt_cnt;
      atten_ff      <= nxt_atten;
      pup_direct_ff <= nxt_pup_direct;
      le_d_ff       <= le_q;
      serial_ff     <= sel_q;
    end
  end

  // Frame capture and statistics
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      frame_ff <= 16'h0000;
      match_ff <= 1'b0;
      acc_ff   <= sac_pkg::RST_COUNT;
      rej_ff   <= sac_pkg::RST_COUNT;
    end
    else
    begin
      if (take_frame)
      begin
        frame_ff <= shift_word;
        match_ff <= addr_hit;
      end
      acc_ff <= bump(acc_ff, accept, clr_cnt);
      rej_ff <= bump(rej_ff, reject, clr_cnt);
    end
  end

  // Read mux
  wire [31:0] rd_status = {20'h00000, le_q, pup_direct_ff,
                           (state_ff == sac_pkg::ST_RUN), serial_ff,
                           atten_ff};
  wire [31:0] rd_frame  = {15'h0000, match_ff, frame_ff};
  wire [31:0] rd_counts = {16'h0000, rej_ff, acc_ff};
  wire [31:0] rd_pins   = {21'h000000, par_q, 1'b0, strap_q};
  wire [31:0] rd_mux    =
    (wb_adr_i == sac_pkg::REG_STATUS) ? rd_status :
    (wb_adr_i == sac_pkg::REG_FRAME)  ? rd_frame  :
    (wb_adr_i == sac_pkg::REG_COUNTS) ? rd_counts :
    (wb_adr_i == sac_pkg::REG_PINS)   ? rd_pins   :
                                        sac_pkg::RST_WORD;

  // One wait state; unmapped addresses ack with zero
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ack_ff  <= 1'b0;
      rdat_ff <= sac_pkg::RST_WORD;
    end
    else
    begin
      ack_ff  <= bus_req;
      rdat_ff <= bus_req ? rd_mux : sac_pkg::RST_WORD;
    end
  end

  assign wb_ack_o    = ack_ff;
  assign wb_dat_o    = rdat_ff;
  assign atten_state = atten_ff;
  assign serial_mode = serial_ff;

endmodule

// file: sac_pkg.sv
// Constants, offsets and types for the step attenuator control port.
// Assumes a 125 MHz system clock; all users reference sac_pkg::name.
package sac_pkg;

  // Frame and word layout
  localparam int FRAME_W   = 16;
  localparam int WORD_W    = 8;
  localparam int PAR_W     = 7;
  localparam int ADDR_W    = 3;
  localparam int ATTEN_LSB = 0;
  localparam int ADDR_LSB  = 8;

  // Attenuation codes: four codes per decibel
  localparam logic [7:0] ATTEN_MAX = 8'h7F;
  localparam logic [7:0] ATTEN_MIN = 8'h00;

  // Power-up timing
  localparam int CLK_MHZ       = 125;
  localparam int PUP_DELAY_US  = 400;
  localparam int PUP_DELAY_CYC = PUP_DELAY_US * CLK_MHZ;
  // Covers the synchroniser fill plus the agreement stage after reset,
  // so the mode pins are read only once their filtered level is valid
  localparam int SETTLE_CYC    = 6;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FRAME  = 8'h08;
  localparam logic [7:0] REG_COUNTS = 8'h0C;
  localparam logic [7:0] REG_PINS   = 8'h10;

  // Field positions
  localparam int CTRL_REINIT   = 0;
  localparam int CTRL_CLRCNT   = 1;
  localparam int ST_SERIAL     = 8;
  localparam int ST_RUNNING    = 9;
  localparam int ST_PUP_DIRECT = 10;
  localparam int ST_LE         = 11;
  localparam int FR_MATCH      = 16;
  localparam int CNT_REJ_LSB   = 8;
  localparam int PINS_PAR_LSB  = 4;

  // Reset values
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [7:0]  RST_COUNT = 8'h00;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_DELAY  = 2'b01,
    ST_RUN    = 2'b10
  } sac_state_t;

endpackage

// file: sac_sync.sv
// Three-stage synchroniser with agreement filter, one per bit.
// Assumes inputs asynchronous to clk_sys; reset is synchronous.
`timescale 1ns/1ns
module sac_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_sys, // System clock
  input  wire logic         sys_rst, // Sync reset, high
  input  wire logic [W-1:0] d,       // Asynchronous input
  output logic      [W-1:0] q        // Filtered level
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  wire  [W-1:0] agree = ~(s2_ff ^ s3_ff);
  wire  [W-1:0] nxt_q = (q & ~agree) | (s3_ff & agree);

  // First stage feeds only the second
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s1_ff <= RST;
      s2_ff <= RST;
      s3_ff <= RST;
      q     <= RST;
    end
    else
    begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q     <= nxt_q;
    end
  end

endmodule

// file: sac_shift.sv
// Serial-in parallel-out frame register on the controller's shift clock.
// Assumes the shift clock stops while the latch strobe is high.
`timescale 1ns/1ns
module sac_shift #(
  parameter int W = 16
) (
  input  wire logic         link_clk,     // Shift clock from controller
  input  wire logic         ser_in,       // Serial data
  input  wire logic         latch_strobe, // Latch strobe pin
  output logic      [W-1:0] frame_ff      // Shifted frame
);

  // LSB arrives first, so it ends up at bit 0
  wire [W-1:0] nxt_frame = {ser_in, frame_ff[W-1:1]};

  // Datapath only; no reset since this clock may stand still
  // shift on rise
  always_ff @(posedge link_clk)
  begin
    if (!latch_strobe)
      frame_ff <= nxt_frame;
  end

endmodule

// file: sac_step_atten_properties.sv
// Checker for the step attenuator control port, bound to its top.
// Assumes synchronous reset on clk_sys and pins held per the contract.
`timescale 1ns/1ns
module sac_step_atten_chk #(
  parameter int PUP_DELAY_CYC = 20
) (
  input wire logic        clk_sys,              // Clock
  input wire logic        sys_rst,              // Reset
  input wire logic        latch_strobe,         // Strobe pin
  input wire logic        sel_serial,           // Mode select
  input wire logic [6:0]  parallel_atten_lines, // Parallel state
  input wire logic        wb_cyc_i,             // Bus cycle
  input wire logic        wb_stb_i,             // Bus strobe
  input wire logic [31:0] wb_dat_o,             // Read data
  input wire logic        wb_ack_o,             // Acknowledge
  input wire logic [7:0]  atten_state,          // Applied state
  input wire logic        serial_mode           // Serial selected
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [15:0] age_ff;
  logic [15:0] nxt_age;
  logic        up;
  // Saturates so long runs never wrap back into power-up
  assign nxt_age = (age_ff == 16'hFFFF) ? age_ff : age_ff + 16'h1;
  assign up = age_ff > 16'(PUP_DELAY_CYC + 16);
  always_ff @(posedge clk_sys)
    age_ff <= sys_rst ? 16'h0 : nxt_age;
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_quiet; (!latch_strobe && !sys_rst)[*8]; endsequence
  sequence s_steady; ($stable(sel_serial) && !sys_rst)[*8]; endsequence
  sequence s_follow;
    (!sel_serial && latch_strobe && up && $stable(parallel_atten_lines))[*8];
  endsequence
  property p_rst_max;
    $fell(sys_rst) |-> atten_state == 8'h7F && !serial_mode;
  endproperty
  property p_pup; age_ff < 16'(PUP_DELAY_CYC) |-> atten_state == 8'h7F;
  endproperty
  property p_mode; s_steady |-> serial_mode == sel_serial; endproperty
  property p_follow; s_follow |-> atten_state[6:0] == parallel_atten_lines;
  endproperty
  property p_hold; s_quiet |=> $stable(atten_state); endproperty
  property p_ack_next; s_req |=> wb_ack_o; endproperty
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_rst_max: assert property (p_rst_max)
    else $error("state not maximum after reset");
  a_pup: assert property (p_pup)
    else $error("state left maximum during power-up");
  a_mode: assert property (p_mode)
    else $error("mode does not follow select");
  a_follow: assert property (p_follow)
    else $error("direct state does not follow lines");
  a_hold: assert property (p_hold)
    else $error("state changed with strobe low");
  a_ack_next: assert property (p_ack_next)
    else $error("no ack one cycle after request");
  a_ack_once: assert property (p_ack_once)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data not zero outside ack");
endmodule
bind sac_step_atten sac_step_atten_chk #(.PUP_DELAY_CYC(PUP_DELAY_CYC))
  u_sac_step_atten_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .latch_strobe(latch_strobe), .sel_serial(sel_serial),
  .parallel_atten_lines(parallel_atten_lines), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .atten_state(atten_state), .serial_mode(serial_mode));

// file: sac_ctrl_model.sv
// Controller model: shift clock, serial data and latch strobe.
// Assumes the link clock stands low outside frames, 80 ns period.
`timescale 1ns/1ns
module sac_ctrl_model (
  output logic link_clk,    // Shift clock
  output logic ser_in,      // Serial data
  output logic latch_strobe // Latch strobe
);
  initial
  begin
    link_clk = 1'b0;
    ser_in = 1'b0;
    latch_strobe = 1'b1;
  end
  task automatic set_strobe(input logic v);
    #3 latch_strobe = v;
  endtask
  task automatic send_frame(input logic [15:0] f);
    #3 latch_strobe = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      ser_in = f[i];
      #40 link_clk = 1'b1;
      #40 link_clk = 1'b0;
    end
    // Released line shows the inverse, not a stale bit
    ser_in = ~f[15];
    #20 latch_strobe = 1'b1;
    #80 latch_strobe = 1'b0;
    #40;
  endtask
endmodule

// file: sac_step_atten_tb.sv
// Bench for the step attenuator control port: pins, frames, bus.
// Assumes the controller model drives the strobe and shift pins.
`timescale 1ns/1ns
module sac_step_atten_tb;
  localparam int PUP = 20;
  logic        clk_sys, sys_rst, sel_serial, wb_cyc_i, wb_stb_i, wb_we_i;
  logic        wb_ack_o, serial_mode, link_clk, ser_in, latch_strobe;
  logic [6:0]  lines;
  logic [2:0]  strap;
  logic [3:0]  wb_sel_i;
  logic [7:0]  wb_adr_i, atten_state;
  logic [31:0] wb_dat_i, wb_dat_o;
  int          miscompares, tests_run, wd_cnt;
  sac_ctrl_model u_sac_ctrl_model (.link_clk(link_clk), .ser_in(ser_in),
    .latch_strobe(latch_strobe));
  sac_step_atten #(.PUP_DELAY_CYC(PUP)) u_sac_step_atten (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .link_clk(link_clk),
    .ser_in(ser_in), .latch_strobe(latch_strobe), .sel_serial(sel_serial),
    .parallel_atten_lines(lines), .addr_strap_bit0(strap[0]),
    .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .atten_state(atten_state),
    .serial_mode(serial_mode));
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic close_out();
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    wd_cnt++;
    if (wd_cnt == 10000)
    begin
      miscompares++;
      close_out();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ca(input string nm, input logic [7:0] e);
    chk(nm, {24'h0, e}, {24'h0, atten_state});
  endtask
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    do
      @(posedge clk_sys);
    while (wb_ack_o !== 1'b1);
    d = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(nm, e, d);
  endtask
  task automatic frame(input logic [15:0] f, input logic [7:0] e);
    u_sac_ctrl_model.send_frame(f);
    cyc(6);
    ca("serial", e);
  endtask
  task automatic t_direct();
    cyc(10);
    ca("pup_hold", 8'h7F);
    cyc(PUP + 40);
    ca("pup_lines", 8'h2A);
    rd("status", sac_pkg::REG_STATUS, 32'h0000_0E2A);
    for (int i = 0; i < 7; i++)
    begin
      lines <= 7'(1 << i);
      cyc(8);
      ca("weight", 8'(1 << i));
    end
  endtask
  task automatic t_latched();
    u_sac_ctrl_model.set_strobe(1'b0);
    cyc(8);
    lines <= 7'h11;
    cyc(12);
    ca("latch_hold", 8'h40);
    u_sac_ctrl_model.set_strobe(1'b1);
    cyc(10);
    u_sac_ctrl_model.set_strobe(1'b0);
    cyc(8);
    lines <= 7'h66;
    cyc(12);
    ca("latch_take", 8'h11);
  endtask
  task automatic t_serial();
    logic [31:0] d;
    lines <= 7'h00;
    sel_serial <= 1'b1;
    cyc(10);
    chk("mode", 32'h1, {31'h0, serial_mode});
    frame(16'hF349, 8'h49);
    frame(16'h0210, 8'h49);
    frame(16'h0B00, 8'h00);
    rd("counts", sac_pkg::REG_COUNTS, 32'h0000_0102);
    rd("frame", sac_pkg::REG_FRAME, 32'h0001_0B00);
    bus(1'b1, sac_pkg::REG_CTRL, 32'h2, d);
    rd("cleared", sac_pkg::REG_COUNTS, 32'h0);
    rd("unmapped", 8'h14, 32'h0);
    rd("pins", sac_pkg::REG_PINS, 32'h3);
  endtask
  task automatic t_switch();
    sel_serial <= 1'b0;
    lines <= 7'h33;
    cyc(10);
    u_sac_ctrl_model.set_strobe(1'b1);
    cyc(10);
    u_sac_ctrl_model.set_strobe(1'b0);
    cyc(8);
    ca("to_par", 8'h33);
    lines <= 7'h00;
    sel_serial <= 1'b1;
    cyc(10);
    frame(16'h0320, 8'h20);
  endtask
  task automatic t_reset_serial();
    sys_rst <= 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    cyc(PUP + 30);
    ca("rst_max", 8'h7F);
    frame(16'h0301, 8'h01);
  endtask
  initial
  begin
    sys_rst = 1'b1;
    sel_serial = 1'b0;
    lines = 7'h2A;
    strap = 3'b011;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_sel_i = 4'h0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    cyc(2);
    sys_rst <= 1'b0;
    t_direct();
    t_latched();
    t_serial();
    t_switch();
    t_reset_serial();
    close_out();
  end
endmodule
